/* sim/fslk_host_model.sv */
// host controller model driving the serial link, mode 0, msb first
`timescale 1ns/1ps
module fslk_host_model (
  input  wire mclk,
  input  wire so,
  input  wire so_oe,
  output reg  sclk,
  output reg  cs_n,
  output reg  si
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  task automatic half;
    repeat (4) @(negedge mclk);
  endtask
  // so is taken at the end of the high phase, where it has long settled
  task automatic xfer(input logic [7:0] b[$], output logic [7:0] rx);
    integer i, k;
    begin
      rx = 8'h00;
      @(negedge mclk);
      cs_n = 1'b0;
      half();
      for (i = 0; i < b.size(); i++) begin
        for (k = 7; k >= 0; k--) begin
          sclk = 1'b0;
          si   = b[i][k];
          half();
          sclk = 1'b1;
          half();
          rx = {rx[6:0], so};
        end
      end
      sclk = 1'b0;
      half();
      cs_n = 1'b1;
      // released line must not keep showing the last bit
      si = ~si;
      repeat (10) @(negedge mclk);
    end
  endtask
endmodule // fslk_host_model

/* sim/fslk_lock_props.sv */
// port-level assertion checker for the sector lock block
`timescale 1ns/1ps
module fslk_lock_props (
  input wire        mclk,
  input wire        rst,
  input wire        ce,
  input wire        sclk,
  input wire        cs_n,
  input wire        si,
  input wire        wp_n,
  input wire        so,
  input wire        so_oe,
  input wire        wip_in,
  input wire        erase_susp_in,
  input wire        prog_susp_in,
  input wire        addr_mode_in,
  input wire        vl_default,
  input wire [25:0] chk_addr,
  input wire        chk_prot,
  input wire        chip_erase_ok,
  input wire        write_enable_latch,
  input wire [1:0]  dummy_cfg,
  input wire        powerup_addr_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_erase_means_open: assert property (chip_erase_ok |-> !chk_prot)
    else $error("chip erase allowed with a protected address");
  // state only moves when a frame ends, so a long low select freezes it
  a_prot_frozen_frame: assert property ((!cs_n [*6]) ##0
    ($past(chk_addr, 1) == $past(chk_addr, 2)) |-> $stable(chk_prot))
    else $error("protection changed inside a frame");
  a_erase_frozen_frame: assert property ((!cs_n [*6]) |-> $stable(chip_erase_ok))
    else $error("chip erase flag changed inside a frame");
  a_latch_moves_idle: assert property ($changed(write_enable_latch) |-> cs_n && $past(cs_n))
    else $error("write latch moved while selected");
  a_dummy_moves_idle: assert property ($changed(dummy_cfg) |-> cs_n)
    else $error("dummy bits moved while selected");
  a_pu_mode_idle: assert property ($changed(powerup_addr_mode) |-> cs_n)
    else $error("power-up mode moved while selected");
  a_out_released: assert property ((cs_n [*6]) |-> !so_oe)
    else $error("output still enabled after deselect");
  a_so_steady_high: assert property ((sclk [*3]) ##0 so_oe && $past(so_oe)
    |-> $stable(so))
    else $error("serial out moved during clock high");
  c_erase_ok: cover property ($rose(chip_erase_ok));
  c_latch_fell: cover property ($fell(write_enable_latch));
  c_read_out: cover property ($rose(so_oe));
endmodule // fslk_lock_props

bind fslk_lock_ctrl fslk_lock_props u_props (.mclk, .rst, .ce, .sclk, .cs_n, .si, .wp_n,
  .so, .so_oe, .wip_in, .erase_susp_in, .prog_susp_in, .addr_mode_in, .vl_default,
  .chk_addr, .chk_prot, .chip_erase_ok, .write_enable_latch, .dummy_cfg, .powerup_addr_mode);

/* sim/test_fslk_lock_ctrl.sv */
// self-checking bench for the sector lock and status bit block
`timescale 1ns/1ps
module test_fslk_lock_ctrl;
  reg         mclk, rst, wp_n, write_in_progress, esus, psus, amode, vld;
  reg  [25:0] addr;
  wire        sclk, cs_n, si, so, so_oe, prot, ceok, write_enable_latch, pu;
  wire [1:0]  dc;
  logic [7:0] rx;
  logic [7:0] bp [4] = '{8'h5C, 8'h60, 8'h64, 8'h68};
  logic [25:0] lim [4] = '{26'h0400000, 26'h0800000, 26'h1000000, 26'h2000000};
  integer     errors, n_tests, i;
  fslk_lock_ctrl u_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .sclk(sclk), .cs_n(cs_n),
    .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .wip_in(write_in_progress), .erase_susp_in(esus),
    .prog_susp_in(psus), .addr_mode_in(amode), .vl_default(vld), .chk_addr(addr),
    .chk_prot(prot), .chip_erase_ok(ceok), .write_enable_latch(write_enable_latch), .dummy_cfg(dc),
    .powerup_addr_mode(pu));
  fslk_host_model u_host (.mclk(mclk), .so(so), .so_oe(so_oe), .sclk(sclk), .cs_n(cs_n),
    .si(si));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      n_tests++;
      if (got !== exp) begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input logic [7:0] b[$]);
    u_host.xfer(b, rx);
  endtask
  task wcmd(input logic [7:0] b[$]);
    begin
      cmd({8'h06});
      cmd(b);
    end
  endtask
  task rd(input logic [7:0] op, input logic [23:0] a);
    cmd({op, a[23:16], a[15:8], a[7:0], 8'h00});
  endtask
  task prot_at(input logic [25:0] a, input logic e);
    begin
      @(negedge mclk);
      addr = a;
      repeat (2) @(negedge mclk);
      chk({7'h00, prot}, {7'h00, e});
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ------------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #3000000;
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    {wp_n, write_in_progress, esus, psus, amode, vld, addr} = {6'b101101, 26'h0};
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    rd(8'hE0, 24'h010000);
    chk(rx, 8'hFF);
    rd(8'hE2, 24'h3FF000);
    chk(rx, 8'h00);
    prot_at(26'h0000000, 1'b1);
    chk({7'h0, ceok}, 8'h00);
    wcmd({8'h98});
    rd(8'hE0, 24'h3FF000);
    chk(rx, 8'h00);
    prot_at(26'h0123456, 1'b0);
    chk({7'h0, ceok}, 8'h01);
    wcmd({8'hE1, 8'h00, 8'h10, 8'h00, 8'h5A});
    chk({7'h0, write_enable_latch}, 8'h01);
    rd(8'hE0, 24'h001000);
    chk(rx, 8'h00);
    cmd({8'hE1, 8'h00, 8'h10, 8'h00, 8'hFF});
    chk({7'h0, write_enable_latch}, 8'h00);
    cmd({8'h06});
    chk({7'h0, write_enable_latch}, 8'h01);
    cmd({8'h04});
    chk({7'h0, write_enable_latch}, 8'h00);
    rd(8'hE0, 24'h001000);
    chk(rx, 8'hFF);
    rd(8'hE0, 24'h000000);
    chk(rx, 8'h00);
    prot_at(26'h0001FFF, 1'b1);
    prot_at(26'h0002000, 1'b0);
    wcmd({8'h7E});
    rd(8'hE0, 24'h3FF000);
    chk(rx, 8'hFF);
    wcmd({8'h98});
    wcmd({8'hE3, 8'h02, 8'h00, 8'h00});
    rd(8'hE2, 24'h020000);
    chk(rx, 8'hFF);
    rd(8'hE2, 24'h030000);
    chk(rx, 8'h00);
    prot_at(26'h002FFFF, 1'b1);
    chk({7'h0, ceok}, 8'h00);
    wcmd({8'hE4});
    rd(8'hE2, 24'h020000);
    chk(rx, 8'h00);
    for (i = 0; i < 4; i++) begin
      wcmd({8'h01, bp[i], 8'h40});
      prot_at(lim[i] - 26'h1, 1'b0);
      prot_at(lim[i], 1'b1);
      cmd({8'h05, 8'h00});
      chk(rx, bp[i]);
    end
    cmd({8'h35, 8'h00});
    chk(rx, 8'hC6);
    wcmd({8'h01, 8'h80, 8'h00});
    wp_n = 1'b0;
    wcmd({8'hE3, 8'h02, 8'h00, 8'h00});
    rd(8'hE2, 24'h020000);
    chk(rx, 8'h00);
    cmd({8'h01, 8'h00, 8'h00});
    cmd({8'h05, 8'h00});
    chk(rx, 8'h82);
    wp_n = 1'b1;
    cmd({8'h01, 8'h00, 8'h00});
    cmd({8'h05, 8'h00});
    chk(rx, 8'h00);
    wcmd({8'h11, 8'hF7});
    amode = 1'b1;
    cmd({8'h15, 8'h00});
    chk(rx, 8'h1B);
    chk({5'h0, pu, dc}, 8'h07);
    wcmd({8'hE1, 8'h03, 8'hFF, 8'h30, 8'h00, 8'hFF});
    cmd({8'hE0, 8'h03, 8'hFF, 8'h30, 8'h00, 8'h00});
    chk(rx, 8'hFF);
    prot_at(26'h3FF3000, 1'b1);
    prot_at(26'h3FF2000, 1'b0);
    amode = 1'b0;
    write_in_progress = 1'b1;
    wcmd({8'h7E});
    cmd({8'h05, 8'h00});
    chk(rx & 8'h01, 8'h01);
    write_in_progress = 1'b0;
    rd(8'hE0, 24'h000000);
    chk(rx, 8'h00);
    stop_test();
  end
endmodule // test_fslk_lock_ctrl

/* src/fslk_lock_ctrl.v */
// serial command front end with lock registers and status bits
`timescale 1ns/1ps
`include "fslk_map.vh"

module fslk_lock_ctrl (
  input  wire        mclk,
  input  wire        rst,
  input  wire        ce,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        si,
  input  wire        wp_n,
  output wire        so,
  output wire        so_oe,
  input  wire        wip_in,
  input  wire        erase_susp_in,
  input  wire        prog_susp_in,
  input  wire        addr_mode_in,
  input  wire        vl_default,
  input  wire [25:0] chk_addr,
  output wire        chk_prot,
  output wire        chip_erase_ok,
  output wire        write_enable_latch,
  output wire [1:0]  dummy_cfg,
  output wire        powerup_addr_mode
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RECV = 3'h2;
  localparam [2:0] ST_EXEC = 3'h4;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  reg  [3:0]  sync1_reg;
  reg  [3:0]  sync2_reg;
  reg         sclk_d_reg;
  reg         cs_d_reg;
  wire        sclk_s;
  wire        cs_s;
  wire        si_s;
  wire        wp_s;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_fall;
  wire        cs_rise;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_reg  <= 4'hE;
      sync2_reg  <= 4'hE;
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else if (ce) begin
      sync1_reg  <= {wp_n, si, cs_n, sclk};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_s;
    end
  end

  assign sclk_s    = sync2_reg[0];
  assign cs_s      = sync2_reg[1];
  assign si_s      = sync2_reg[2];
  assign wp_s      = sync2_reg[3];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign cs_fall   = ~cs_s & cs_d_reg;
  assign cs_rise   = cs_s & ~cs_d_reg;

  // --------------------------------------------------------------------
  // state and storage
  // --------------------------------------------------------------------
  reg  [2:0]    state_reg;
  reg  [2:0]    bit_cnt_reg;
  reg  [2:0]    nbytes_reg;
  reg  [7:0]    sh_reg;
  reg  [7:0]    op_reg;
  reg  [31:0]   addr_reg;
  reg  [7:0]    b1_reg;
  reg  [7:0]    b2_reg;
  reg  [7:0]    dat_reg;
  reg  [7:0]    tx_reg;
  reg           so_reg;
  reg           so_oe_reg;
  reg           wel_reg;
  reg           init_reg;
  reg           prot_lo_reg;
  reg           prot_hi_reg;
  reg  [4:0]    bp_reg;
  reg           cmp_reg;
  reg  [2:0]    sec_reg;
  reg           pu_addr_reg;
  reg  [1:0]    dc_reg;
  reg           chk_prot_reg;
  reg           ce_ok_reg;
  reg  [1053:0] vl_reg;
  reg  [1053:0] nl_reg;
  wire [2:0]    alen;
  wire [7:0]    byte_in;
  wire [10:0]   wr_idx;
  wire [10:0]   chk_idx;
  wire          in_exec;
  wire          wr_ok;
  wire          sr_locked;
  wire          rd_op;
  wire          do_wren;
  wire          do_wrdi;
  wire          do_vl_all;
  wire          vl_good;
  wire          do_vl_one;
  wire          do_nl_set;
  wire          do_nl_clr;
  wire          do_sr1;
  wire          do_sr2;
  wire          do_sr3;
  wire          bp_none;
  reg  [7:0]    sr1;
  reg  [7:0]    sr2;
  reg  [7:0]    sr3;
  reg  [7:0]    resp;

  assign alen    = addr_mode_in ? 3'h4 : 3'h3;
  assign byte_in = {sh_reg[6:0], si_s};

  // --------------------------------------------------------------------
  // block protect region
  // --------------------------------------------------------------------
  function bp_hit;
    input [9:0] blk;
    input [4:0] bp;
    input       cmp;
    reg   [10:0] cnt;
    reg          hit;
    begin
      cnt = 11'h000;
      if (bp[3:2] == 2'h3 || bp[3:0] == 4'hB) begin
        hit = 1'b1;
      end else if (bp[3:0] == 4'h0) begin
        hit = 1'b0;
      end else begin
        cnt = 11'h001 << (bp[3:0] - 4'h1);
        if (bp[4]) begin
          hit = ({1'b0, blk} < cnt);
        end else begin
          hit = ({1'b0, blk} >= (`FSLK_NUM_BLOCKS - cnt));
        end
      end
      bp_hit = hit ^ cmp;
    end
  endfunction

  assign bp_none = cmp_reg ? (bp_reg[3:2] == 2'h3 || bp_reg[3:0] == 4'hB)
                           : (bp_reg[3:0] == 4'h0);

  // --------------------------------------------------------------------
  // address decode for command and check port
  // --------------------------------------------------------------------
  fslk_lock_index u_wr_index (
    .addr (addr_reg[25:0]),
    .idx  (wr_idx)
  );

  fslk_lock_index u_chk_index (
    .addr (chk_addr),
    .idx  (chk_idx)
  );

  // --------------------------------------------------------------------
  // status bytes
  // --------------------------------------------------------------------
  always @* begin
    sr1 = 8'h00;
    sr1[`FSLK_SR1_PROT_LO] = prot_lo_reg;
    sr1[`FSLK_SR1_BP_HI:`FSLK_SR1_BP_LO] = bp_reg;
    sr1[`FSLK_SR1_WEL] = wel_reg;
    sr1[`FSLK_SR1_WIP] = wip_in;
    sr2 = 8'h00;
    sr2[`FSLK_SR2_ERS_SUSP] = erase_susp_in;
    sr2[`FSLK_SR2_CMP] = cmp_reg;
    sr2[`FSLK_SR2_SEC_HI:`FSLK_SR2_SEC_LO] = sec_reg;
    sr2[`FSLK_SR2_PRG_SUSP] = prog_susp_in;
    sr2[`FSLK_SR2_QUAD] = `FSLK_QUAD_VAL;
    sr2[`FSLK_SR2_PROT_HI] = prot_hi_reg;
    sr3 = 8'h00;
    sr3[`FSLK_SR3_PU_ADDR] = pu_addr_reg;
    sr3[`FSLK_SR3_CUR_ADDR] = addr_mode_in;
    sr3[`FSLK_SR3_DC_HI:`FSLK_SR3_DC_LO] = dc_reg;
  end

  // --------------------------------------------------------------------
  // read response
  // --------------------------------------------------------------------
  assign rd_op = (op_reg == `FSLK_OP_RD_SR1) || (op_reg == `FSLK_OP_RD_SR2) ||
                 (op_reg == `FSLK_OP_RD_SR3) || (op_reg == `FSLK_OP_RD_VLOCK) ||
                 (op_reg == `FSLK_OP_RD_NLOCK);

  always @* begin
    resp = 8'h00;
    case (op_reg)
      `FSLK_OP_RD_SR1: resp = sr1;
      `FSLK_OP_RD_SR2: resp = sr2;
      `FSLK_OP_RD_SR3: resp = sr3;
      `FSLK_OP_RD_VLOCK: begin
        if (nbytes_reg > alen) resp = {8{vl_reg[wr_idx]}};
      end
      `FSLK_OP_RD_NLOCK: begin
        if (nbytes_reg > alen) resp = {8{nl_reg[wr_idx]}};
      end
      default: resp = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // command execution at chip select release
  // --------------------------------------------------------------------
  // partial bytes and a busy array abort any write
  assign in_exec   = (state_reg == ST_EXEC) && (bit_cnt_reg == 3'h0) && ~wip_in;
  assign wr_ok     = in_exec && wel_reg;
  assign sr_locked = prot_hi_reg | (prot_lo_reg & ~wp_s);
  assign do_wren   = in_exec && (nbytes_reg == 3'h1) && (op_reg == `FSLK_OP_WR_ENABLE);
  assign do_wrdi   = in_exec && (nbytes_reg == 3'h1) && (op_reg == `FSLK_OP_WR_DISABLE);
  assign do_vl_all = wr_ok && (nbytes_reg == 3'h1) &&
                     ((op_reg == `FSLK_OP_VLOCK_CLR) || (op_reg == `FSLK_OP_VLOCK_SET));
  assign vl_good   = (dat_reg == `FSLK_LOCK_OPEN) || (dat_reg == `FSLK_LOCK_SHUT);
  assign do_vl_one = wr_ok && (op_reg == `FSLK_OP_WR_VLOCK) &&
                     (nbytes_reg == alen + 3'h2) && vl_good;
  assign do_nl_set = wr_ok && ~sr_locked && (op_reg == `FSLK_OP_SET_NLOCK) &&
                     (nbytes_reg == alen + 3'h1);
  assign do_nl_clr = wr_ok && ~sr_locked && (op_reg == `FSLK_OP_CLR_NLOCK) &&
                     (nbytes_reg == 3'h1);
  assign do_sr1    = wr_ok && ~sr_locked && (op_reg == `FSLK_OP_WR_SR12) &&
                     (nbytes_reg >= 3'h2);
  assign do_sr2    = do_sr1 && (nbytes_reg >= 3'h3);
  assign do_sr3    = wr_ok && ~sr_locked && (op_reg == `FSLK_OP_WR_SR3) &&
                     (nbytes_reg >= 3'h2);

  // --------------------------------------------------------------------
  // serial receive, transmit and sequencing
  // --------------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      nbytes_reg  <= 3'h0;
      sh_reg      <= 8'h00;
      op_reg      <= 8'h00;
      addr_reg    <= 32'h0000_0000;
      b1_reg      <= 8'h00;
      b2_reg      <= 8'h00;
      dat_reg     <= 8'h00;
      tx_reg      <= 8'h00;
      so_reg      <= 1'b0;
      so_oe_reg   <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          so_oe_reg <= 1'b0;
          if (cs_fall) begin
            state_reg   <= ST_RECV;
            bit_cnt_reg <= 3'h0;
            nbytes_reg  <= 3'h0;
            op_reg      <= 8'h00;
            addr_reg    <= 32'h0000_0000;
          end
        end
        ST_RECV: begin
          so_oe_reg <= rd_op;
          if (cs_rise) begin
            state_reg <= ST_EXEC;
            so_oe_reg <= 1'b0;
          end else if (sclk_rise) begin
            sh_reg      <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              if (nbytes_reg != 3'h7) nbytes_reg <= nbytes_reg + 3'h1;
              if (nbytes_reg == 3'h0) op_reg <= byte_in;
              if (nbytes_reg == 3'h1) b1_reg <= byte_in;
              if (nbytes_reg == 3'h2) b2_reg <= byte_in;
              if (nbytes_reg != 3'h0 && nbytes_reg <= alen) begin
                addr_reg <= {addr_reg[23:0], byte_in};
              end
              if (nbytes_reg == alen + 3'h1) dat_reg <= byte_in;
            end
          end else if (sclk_fall) begin
            // reload on each byte boundary so status reads repeat
            if (bit_cnt_reg == 3'h0 && nbytes_reg != 3'h0) begin
              so_reg <= resp[7];
              tx_reg <= {resp[6:0], 1'b0};
            end else begin
              so_reg <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        end
        ST_EXEC: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // write latch and status fields
  // --------------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wel_reg     <= 1'b0;
      prot_lo_reg <= 1'b0;
      prot_hi_reg <= 1'b0;
      bp_reg      <= `FSLK_BP_RST;
      cmp_reg     <= 1'b0;
      sec_reg     <= `FSLK_SEC_RST;
      pu_addr_reg <= 1'b0;
      dc_reg      <= `FSLK_DC_RST;
    end else if (ce) begin
      if (do_wren) begin
        wel_reg <= 1'b1;
      end else if (do_wrdi || do_vl_all || do_vl_one || do_nl_set || do_nl_clr ||
                   do_sr1 || do_sr3) begin
        wel_reg <= 1'b0;
      end
      if (do_sr1) begin
        prot_lo_reg <= b1_reg[`FSLK_SR1_PROT_LO];
        bp_reg      <= b1_reg[`FSLK_SR1_BP_HI:`FSLK_SR1_BP_LO];
      end
      if (do_sr2) begin
        cmp_reg     <= b2_reg[`FSLK_SR2_CMP];
        sec_reg     <= sec_reg | b2_reg[`FSLK_SR2_SEC_HI:`FSLK_SR2_SEC_LO];
        prot_hi_reg <= b2_reg[`FSLK_SR2_PROT_HI];
      end
      if (do_sr3) begin
        pu_addr_reg <= b1_reg[`FSLK_SR3_PU_ADDR];
        dc_reg      <= b1_reg[`FSLK_SR3_DC_HI:`FSLK_SR3_DC_LO];
      end
    end
  end

  // --------------------------------------------------------------------
  // lock arrays, one bit per entry since only 00h and FFh are legal
  // --------------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_reg <= 1'b1;
    end else if (ce) begin
      init_reg <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FSLK_NUM_LOCKS; gi = gi + 1) begin : g_lock
      localparam [10:0] IDX = gi;
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          vl_reg[gi] <= 1'b0;
          nl_reg[gi] <= 1'b0;
        end else if (ce) begin
          if (init_reg) begin
            vl_reg[gi] <= vl_default;
          end else if (do_vl_all) begin
            vl_reg[gi] <= (op_reg == `FSLK_OP_VLOCK_SET);
          end else if (do_vl_one && wr_idx == IDX) begin
            vl_reg[gi] <= dat_reg[0];
          end
          if (do_nl_clr) begin
            nl_reg[gi] <= 1'b0;
          end else if (do_nl_set && wr_idx == IDX) begin
            nl_reg[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // protection check for program and erase
  // --------------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      chk_prot_reg <= 1'b1;
      ce_ok_reg    <= 1'b0;
    end else if (ce) begin
      // volatile locks still loading on the first edge, so stay protected
      chk_prot_reg <= init_reg | bp_hit(chk_addr[25:16], bp_reg, cmp_reg) |
                      vl_reg[chk_idx] | nl_reg[chk_idx];
      ce_ok_reg    <= ~init_reg & bp_none & ~(|vl_reg) & ~(|nl_reg);
    end
  end

  assign so                = so_reg;
  assign so_oe             = so_oe_reg;
  assign chk_prot          = chk_prot_reg;
  assign chip_erase_ok     = ce_ok_reg;
  assign write_enable_latch               = wel_reg;
  assign dummy_cfg         = dc_reg;
  assign powerup_addr_mode = pu_addr_reg;

endmodule // fslk_lock_ctrl

/* src/fslk_lock_index.v */
// address to lock register index decode
`timescale 1ns/1ps
`include "fslk_map.vh"

module fslk_lock_index (
  input  wire [25:0] addr,
  output reg  [10:0] idx
);

  wire [9:0] blk;
  wire [3:0] sec;

  assign blk = addr[25:16];
  assign sec = addr[15:12];

  // --------------------------------------------------------------------
  // end blocks per sector, middle blocks per block
  // --------------------------------------------------------------------
  always @* begin
    if (blk == `FSLK_BOT_BLOCK) begin
      idx = {7'h00, sec};
    end else if (blk == `FSLK_TOP_BLOCK) begin
      idx = `FSLK_TOP_BASE + {7'h00, sec};
    end else begin
      idx = {1'b0, blk} + `FSLK_MID_OFS;
    end
  end

endmodule // fslk_lock_index

/* src/fslk_map.vh */
// constants for the sector lock and status bit block
`ifndef FSLK_MAP_VH
`define FSLK_MAP_VH

// ----------------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------------
`define FSLK_OP_WR_ENABLE  8'h06
`define FSLK_OP_WR_DISABLE 8'h04
`define FSLK_OP_RD_SR1     8'h05
`define FSLK_OP_RD_SR2     8'h35
`define FSLK_OP_RD_SR3     8'h15
`define FSLK_OP_WR_SR12    8'h01
`define FSLK_OP_WR_SR3     8'h11
`define FSLK_OP_RD_VLOCK   8'hE0
`define FSLK_OP_WR_VLOCK   8'hE1
`define FSLK_OP_RD_NLOCK   8'hE2
`define FSLK_OP_SET_NLOCK  8'hE3
`define FSLK_OP_CLR_NLOCK  8'hE4
`define FSLK_OP_VLOCK_CLR  8'h98
`define FSLK_OP_VLOCK_SET  8'h7E

// ----------------------------------------------------------------------
// lock array layout
// ----------------------------------------------------------------------
`define FSLK_NUM_LOCKS     1054
`define FSLK_IDX_W         11
`define FSLK_ADDR_W        26
`define FSLK_BOT_BLOCK     10'h000
`define FSLK_TOP_BLOCK     10'h3FF
`define FSLK_MID_OFS       11'h00F
`define FSLK_TOP_BASE      11'h40E
`define FSLK_NUM_BLOCKS    11'h400
`define FSLK_LOCK_OPEN     8'h00
`define FSLK_LOCK_SHUT     8'hFF

// ----------------------------------------------------------------------
// status byte one field positions
// ----------------------------------------------------------------------
`define FSLK_SR1_PROT_LO   7
`define FSLK_SR1_BP_HI     6
`define FSLK_SR1_BP_LO     2
`define FSLK_SR1_WEL       1
`define FSLK_SR1_WIP       0

// ----------------------------------------------------------------------
// status byte two field positions
// ----------------------------------------------------------------------
`define FSLK_SR2_ERS_SUSP  7
`define FSLK_SR2_CMP       6
`define FSLK_SR2_SEC_HI    5
`define FSLK_SR2_SEC_LO    3
`define FSLK_SR2_PRG_SUSP  2
`define FSLK_SR2_QUAD      1
`define FSLK_SR2_PROT_HI   0

// ----------------------------------------------------------------------
// status byte three field positions
// ----------------------------------------------------------------------
`define FSLK_SR3_PU_ADDR   4
`define FSLK_SR3_CUR_ADDR  3
`define FSLK_SR3_DC_HI     1
`define FSLK_SR3_DC_LO     0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FSLK_BP_RST        5'h00
`define FSLK_SEC_RST       3'h0
`define FSLK_DC_RST        2'h0
`define FSLK_QUAD_VAL      1'b1

`endif
